// ==== bench/stream_sink.sv ====
/*
 * downstream sink model for the three-channel sample stream.
 * assumes valid and data hold until ready is sampled high on clk_i.
 */
`timescale 1ns/1ns

// ****************************************
// sink
// ****************************************
module stream_sink (
    // clock
    input wire logic clk_i,
    // pacing from the bench
    input wire logic hold_i,
    input wire logic slow_i,
    // stream from the core
    input wire logic valid_i,
    input wire audio_core_pkg::trio_t data_i,
    output logic ready_o,
    // what arrived
    output int n_got,
    output audio_core_pkg::trio_t last_o
);
    initial begin
        ready_o = 1'b0;
        n_got = 0;
        last_o = '0;
    end
    // takes a word only on an edge with both valid and ready
    always @(posedge clk_i) begin
        if (valid_i === 1'b1 && ready_o === 1'b1) begin
            n_got <= n_got + 1;
            last_o <= data_i;
        end
        ready_o <= #1 !hold_i && (!slow_i || !ready_o);
    end
endmodule

// ==== bench/tb_top.sv ====
/*
 * self-checking bench for audio_core: register window, transfer, stream.
 * assumes stream_sink as the downstream partner.
 */
`timescale 1ns/1ns

module tb_top;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic coef_xfer_i = 1'b0;
    logic compression_mode_i = 1'b0;
    logic [3:0] limiter_attack_threshold_i = 4'h6;
    logic [3:0] limiter_release_threshold_i = 4'h9;
    logic [2:0] crossover_select_i = 3'h1;
    logic post_scale_link_i = 1'b0;
    logic in_valid_i = 1'b0;
    audio_core_pkg::stereo_t in_data_i = '0;
    logic in_ready_o;
    logic out_valid_o;
    audio_core_pkg::trio_t out_data_o;
    logic out_ready_i;
    logic hold = 1'b0;
    logic slow = 1'b0;
    int n_got;
    audio_core_pkg::trio_t last;
    audio_core_pkg::trio_t snap;
    int n_mismatch = 0;
    int tests_run = 0;
    int acc;
    int base;
    row_t rows [0:7] = '{'{8'h16, 8'h0A, 8'h0A}, '{8'h17, 8'hA5, 8'hA5}, '{8'h18, 8'h5A, 8'h5A},
        '{8'h19, 8'hFF, 8'hFF}, '{8'h1A, 8'h81, 8'h81}, '{8'h1B, 8'h7E, 8'h7E}, '{8'h1C, 8'h01, 8'h01},
        '{8'h1D, 8'h33, 8'h00}};

    always #20 clk_i = ~clk_i;

    audio_core dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .coef_xfer_i(coef_xfer_i),
        .compression_mode_i(compression_mode_i), .limiter_attack_threshold_i(limiter_attack_threshold_i),
        .limiter_release_threshold_i(limiter_release_threshold_i), .crossover_select_i(crossover_select_i),
        .post_scale_link_i(post_scale_link_i), .in_valid_i(in_valid_i), .in_data_i(in_data_i),
        .in_ready_o(in_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));

    stream_sink sink_u (.clk_i(clk_i), .hold_i(hold), .slow_i(slow), .valid_i(out_valid_o),
        .data_i(out_data_o), .ready_o(out_ready_i), .n_got(n_got), .last_o(last));

    // ****************************************
    // helpers
    // ****************************************
    task conclude;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(posedge clk_i);
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        reg_wr_i = 1'b0;
        reg_addr_i = a;
        @(posedge clk_i);
        #1 chk(reg_rdata_o === e, "register readback");
    endtask

    task load(input logic [7:0] a, input logic [23:0] w1, input logic [23:0] w2);
        wr(8'h16, a);
        for (int i = 0; i < 3; i++) begin
            wr(8'h17 + 8'(i), w1[23 - 8 * i -: 8]);
            wr(8'h1A + 8'(i), w2[23 - 8 * i -: 8]);
        end
        reg_wr_i = 1'b0;
        coef_xfer_i = 1'b1;
        @(posedge clk_i);
        #1 coef_xfer_i = 1'b0;
    endtask

    task push(input logic [23:0] s0, input logic [23:0] s1);
        int n;
        n = 0;
        base = n_got;
        in_data_i.ch[0] = s0;
        in_data_i.ch[1] = s1;
        in_valid_i = 1'b1;
        while (in_ready_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        @(posedge clk_i);
        #1 in_valid_i = 1'b0;
        n = 0;
        while (n_got == base && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk(n_got == base + 1, "sample not delivered");
    endtask

    initial begin
        #(40 * 5000);
        n_mismatch++;
        conclude();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'h16 + 8'(i), 8'h00);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        load(8'h00, 24'h000000, 24'h000000);
        // inverted unity on out1 from in1, zero from in2
        load(8'h0A, 24'h800000, 24'h000000);
        slow = 1'b1;
        push(24'h100000, 24'h000000);
        chk(last.ch[0][23] === 1'b1, "phase not inverted");
        chk(last.ch[1] === 24'h000000, "out2 not from in2 alone");
        chk(last.ch[2][23] === 1'b0, "out3 sign wrong");
        // channel 1 post-scale zero, linked to every channel
        load(8'h10, 24'h000000, 24'h7FFFFF);
        post_scale_link_i = 1'b1;
        push(24'h100000, 24'h100000);
        chk(last === '0, "link not applied");
        post_scale_link_i = 1'b0;
        push(24'h100000, 24'h100000);
        chk(last.ch[1] !== 24'h000000, "channel 2 own factor unused");
        // stall downstream until the fifo refuses
        slow = 1'b0;
        hold = 1'b1;
        base = n_got;
        in_data_i = '0;
        in_valid_i = 1'b1;
        acc = 0;
        for (int i = 0; i < 48; i++) begin
            acc += (in_ready_o === 1'b1);
            if (i == 10) begin
                snap = out_data_o;
            end
            @(posedge clk_i);
            #1;
        end
        in_valid_i = 1'b0;
        chk(acc == 33 && in_ready_o === 1'b0, "fifo depth wrong");
        chk(out_valid_o === 1'b1 && out_data_o === snap && snap === '0, "output moved while stalled");
        hold = 1'b0;
        repeat (80) @(posedge clk_i);
        #1 chk(n_got == base + acc && last === '0 && out_valid_o === 1'b0, "drain count wrong");
        conclude();
    end
endmodule

// ==== core/audio_core.sv ====
/*
 * stereo-in, three-channel-out processing core with its fifo:
 * pre-scale, eq biquad, mix, crossover, limiter gain, post-scale.
 * assumes register port, stream and control inputs on clk_i.
 */
// Functional notes
// - anti-clip release code 0 is minus infinity, 1 is -29 dB up to 0 dB.
// - compression attack code 0 is -31 dB up to -4 dB below volume.
// - compression release code 0 minus infinity, 1 is -38 up to -6 dB.
// - biquad output sums five products; halved b0, b1, a1 are doubled.
// - biquad coefficients are signed fractions from -1 up to just under +1.
// - biquad slots hold b1/2, b2, -a1/2, -a2, b0/2 per channel and biquad.
// - one pre-scale multiplier per channel, reset to maximum positive code.
// - one 24-bit post-scale multiply per channel at the end of the path.
// - post-scale factors live in coefficient ram, loaded via the window.
// - link bit makes every channel use channel 1 post-scale factor.
// - each of three outputs is a weighted sum of two filtered inputs.
// - mix coefficients are 24-bit two's complement fractions.
// - crossover filters follow the mix, chosen by crossover select.
// - crossover select 000 uses user second-order coefficients.
// - crossover defaults to pass-through and feeds the limiter stage.
// - 7FFFFF is unity gain, 800000 is unity gain inverted.
// - coefficient address register at 16h, resets to zero.
// - first coefficient bytes at 17h, 18h, 19h, reset zero.
// - second coefficient bytes at 1Ah, 1Bh, 1Ch, reset zero.
// - compression mode bit selects which threshold decode applies.
// - peak above attack threshold lowers the gain at the attack step.
// - rms below release threshold raises gain, never above unity.
`timescale 1ns/1ns

// ****************************************
// fifo
// ****************************************
module sync_fifo #(
    parameter int W = 48,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic wr_valid_i,
    input wire logic [W-1:0] wr_data_i,
    output logic wr_ready_o,
    // drain side
    output logic rd_valid_o,
    output logic [W-1:0] rd_data_o,
    input wire logic rd_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = wr_valid_i && wr_ready_o;
    wire pop = rd_valid_o && rd_ready_i;
    wire [AW:0] count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign rd_data_o = mem_reg[rd_ptr_reg];
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= wr_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            wr_ready_o <= 1'b0;
            rd_valid_o <= 1'b0;
        end else begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg <= count_next;
            wr_ready_o <= count_next != (AW+1)'(DEPTH);
            rd_valid_o <= count_next != '0;
        end
    end
endmodule

// ****************************************
// processing core
// ****************************************
module audio_core #(
    parameter int DEPTH = 32,
    parameter logic [23:0] GAIN_STEP = audio_core_pkg::GAIN_STEP_DEF
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    output logic [7:0] reg_rdata_o,
    // transfer command and control bits
    input wire logic coef_xfer_i,
    input wire logic compression_mode_i,
    input wire logic [3:0] limiter_attack_threshold_i,
    input wire logic [3:0] limiter_release_threshold_i,
    input wire logic [2:0] crossover_select_i,
    input wire logic post_scale_link_i,
    // sample stream in
    input wire logic in_valid_i,
    input wire audio_core_pkg::stereo_t in_data_i,
    output logic in_ready_o,
    // sample stream out
    output logic out_valid_o,
    output audio_core_pkg::trio_t out_data_o,
    input wire logic out_ready_i
);
    function automatic logic signed [23:0] sat24(input logic signed [55:0] v);
        if (v > 56'sh00000000_7FFFFF) begin
            return audio_core_pkg::UNITY;
        end
        if (v < -56'sh00000000_800000) begin
            return audio_core_pkg::NEG_UNITY;
        end
        return v[23:0];
    endfunction

    function automatic logic signed [23:0] biquad(input logic signed [23:0] x, x1, x2, y1, y2,
            input logic [4:0][23:0] c);
        logic signed [55:0] half;
        logic signed [55:0] full;
        half = x * $signed(c[4]) + x1 * $signed(c[0]) + y1 * $signed(c[2]);
        full = x2 * $signed(c[1]) + y2 * $signed(c[3]);
        return sat24(((half <<< 1) + full) >>> 23);
    endfunction

    function automatic logic signed [8:0] level_db(input logic [23:0] v);
        int lz;
        lz = 24;
        for (int i = 0; i < 24; i++) begin
            if (v[i]) begin
                lz = 23 - i;
            end
        end
        return 9'(-audio_core_pkg::DB_PER_BIT * lz);
    endfunction

    function automatic logic [23:0] coef_default(input int w);
        if (w < audio_core_pkg::MIX_BASE || w >= audio_core_pkg::XO_BASE) begin
            return (((w >= audio_core_pkg::XO_BASE) ? w - audio_core_pkg::XO_BASE : w) % audio_core_pkg::SLOTS ==
                audio_core_pkg::SLOT_HALF_B0) ? audio_core_pkg::HALF_ONE : 24'h000000;
        end
        if (w >= audio_core_pkg::POST_BASE || w == 10 || w == 13) begin
            return audio_core_pkg::UNITY;
        end
        return (w >= 14) ? audio_core_pkg::HALF_ONE : 24'h000000;
    endfunction

    // ****************************************
    // register window
    // ****************************************
    logic [7:0] coef_addr_reg;
    logic [23:0] first_coef_data_bits_reg;
    logic [23:0] second_coef_data_bits_reg;
    logic [7:0] rdata_next;
    wire wr_addr = reg_wr_i && reg_addr_i == audio_core_pkg::ADDR_COEF_ADDR;
    wire [5:0] wr_byte = {6{reg_wr_i}} & {reg_addr_i == audio_core_pkg::ADDR_SECOND_LO,
        reg_addr_i == audio_core_pkg::ADDR_SECOND_MID, reg_addr_i == audio_core_pkg::ADDR_SECOND_HI,
        reg_addr_i == audio_core_pkg::ADDR_FIRST_LO, reg_addr_i == audio_core_pkg::ADDR_FIRST_MID,
        reg_addr_i == audio_core_pkg::ADDR_FIRST_HI};
    wire [47:0] window = {first_coef_data_bits_reg, second_coef_data_bits_reg};
    wire [7:0] sel = reg_addr_i - audio_core_pkg::ADDR_FIRST_HI;
    assign rdata_next = wr_addr ? 8'h00 : (reg_addr_i == audio_core_pkg::ADDR_COEF_ADDR) ? coef_addr_reg :
        (sel < 8'h06) ? window[47 - 8 * sel[2:0] -: 8] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            coef_addr_reg <= audio_core_pkg::BYTE_RESET;
            reg_rdata_o <= 8'h00;
        end else begin
            coef_addr_reg <= wr_addr ? reg_wdata_i : coef_addr_reg;
            reg_rdata_o <= (reg_addr_i == audio_core_pkg::ADDR_COEF_ADDR) ? coef_addr_reg : rdata_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_bytes
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    first_coef_data_bits_reg[23 - 8 * g -: 8] <= audio_core_pkg::BYTE_RESET;
                    second_coef_data_bits_reg[23 - 8 * g -: 8] <= audio_core_pkg::BYTE_RESET;
                end else begin
                    if (wr_byte[g]) begin
                        first_coef_data_bits_reg[23 - 8 * g -: 8] <= reg_wdata_i;
                    end
                    if (wr_byte[g + 3]) begin
                        second_coef_data_bits_reg[23 - 8 * g -: 8] <= reg_wdata_i;
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // coefficient ram and pre-scale
    // ****************************************
    logic [23:0] coef_mem_reg [audio_core_pkg::COEF_WORDS];
    logic [27:0] prescale_reg [2];
    wire [7:0] addr_second = coef_addr_reg + 8'h01;
    generate
        for (g = 0; g < audio_core_pkg::COEF_WORDS; g++) begin : gen_ram
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    coef_mem_reg[g] <= coef_default(g);
                end else if (coef_xfer_i && coef_addr_reg == 8'(g)) begin
                    coef_mem_reg[g] <= first_coef_data_bits_reg;
                end else if (coef_xfer_i && addr_second == 8'(g)) begin
                    coef_mem_reg[g] <= second_coef_data_bits_reg;
                end
            end
        end
        for (g = 0; g < 2; g++) begin : gen_pre
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    prescale_reg[g] <= audio_core_pkg::PRESCALE_RESET;
                end else if (coef_xfer_i && coef_addr_reg == 8'(audio_core_pkg::PRE_BASE + g)) begin
                    prescale_reg[g] <= {first_coef_data_bits_reg, 4'h0};
                end
            end
        end
    endgenerate

    // ****************************************
    // stream and eq
    // ****************************************
    audio_core_pkg::stereo_t head;
    logic head_valid;
    wire pop = head_valid && (!out_valid_o || out_ready_i);
    sync_fifo #(.W(48), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .wr_valid_i(in_valid_i),
        .wr_data_i(in_data_i),
        .wr_ready_o(in_ready_o),
        .rd_valid_o(head_valid),
        .rd_data_o(head),
        .rd_ready_i(pop)
    );

    logic signed [23:0] eq_out [2];
    generate
        for (g = 0; g < 2; g++) begin : gen_eq
            logic signed [23:0] st_reg [4];
            logic [4:0][23:0] c;
            logic signed [55:0] pre_prod;
            wire signed [23:0] x = head.ch[g];
            wire signed [23:0] pre = sat24(pre_prod >>> 27);
            assign pre_prod = x * $signed(prescale_reg[g]);
            for (genvar s = 0; s < 5; s++) begin : gen_c
                assign c[s] = coef_mem_reg[g * audio_core_pkg::SLOTS + s];
            end
            assign eq_out[g] = biquad(pre, st_reg[0], st_reg[1], st_reg[2], st_reg[3], c);
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    st_reg <= '{default: '0};
                end else if (pop) begin
                    st_reg <= '{pre, st_reg[0], eq_out[g], st_reg[2]};
                end
            end
        end
    endgenerate

    // ****************************************
    // mix, crossover, limiter gain, post-scale
    // ****************************************
    logic [23:0] gain_reg;
    logic [23:0] rms_reg;
    logic signed [23:0] lim_out [3];
    audio_core_pkg::trio_t out_next;
    generate
        for (g = 0; g < 3; g++) begin : gen_out
            logic signed [23:0] st_reg [4];
            logic [4:0][23:0] c;
            logic signed [55:0] mix_sum;
            logic signed [55:0] lim_prod;
            logic signed [55:0] post_prod;
            wire [23:0] ps = coef_mem_reg[post_scale_link_i ? audio_core_pkg::POST_BASE :
                audio_core_pkg::POST_BASE + g];
            wire signed [23:0] mixed = sat24(mix_sum >>> 23);
            wire signed [23:0] xo = (crossover_select_i == 3'h0) ?
                biquad(mixed, st_reg[0], st_reg[1], st_reg[2], st_reg[3], c) : mixed;
            assign mix_sum = eq_out[0] * $signed(coef_mem_reg[audio_core_pkg::MIX_BASE + 2 * g]) +
                eq_out[1] * $signed(coef_mem_reg[audio_core_pkg::MIX_BASE + 2 * g + 1]);
            for (genvar s = 0; s < 5; s++) begin : gen_c
                assign c[s] = coef_mem_reg[audio_core_pkg::XO_BASE + g * audio_core_pkg::SLOTS + s];
            end
            assign lim_prod = xo * $signed({1'b0, gain_reg[22:0]});
            assign lim_out[g] = sat24(lim_prod >>> 23);
            assign post_prod = lim_out[g] * $signed(ps);
            assign out_next.ch[g] = sat24(post_prod >>> 23);
            always_ff @(posedge clk_i) begin
                if (!rst_b_i) begin
                    st_reg <= '{default: '0};
                end else if (pop) begin
                    st_reg <= '{mixed, st_reg[0], xo, st_reg[2]};
                end
            end
        end
    endgenerate

    // ****************************************
    // limiter
    // ****************************************
    logic signed [8:0] att_db;
    logic signed [8:0] rel_db;
    wire [7:0] att8 = compression_mode_i ? audio_core_pkg::DRC_ATT_DB[limiter_attack_threshold_i] :
        audio_core_pkg::AC_ATT_DB[limiter_attack_threshold_i];
    wire [7:0] rel8 = compression_mode_i ? audio_core_pkg::DRC_REL_DB[limiter_release_threshold_i] :
        audio_core_pkg::AC_REL_DB[limiter_release_threshold_i];
    wire rel_inf = limiter_release_threshold_i == 4'h0;
    assign att_db = {att8[7], att8};
    assign rel_db = compression_mode_i ? att_db + {rel8[7], rel8} : {rel8[7], rel8};
    wire [23:0] a0 = lim_out[0][23] ? 24'(-lim_out[0]) : lim_out[0];
    wire [23:0] a1 = lim_out[1][23] ? 24'(-lim_out[1]) : lim_out[1];
    wire [23:0] a2 = lim_out[2][23] ? 24'(-lim_out[2]) : lim_out[2];
    wire [23:0] a01 = (a0 > a1) ? a0 : a1;
    wire [23:0] peak = (a01 > a2) ? a01 : a2;
    wire signed [24:0] rms_diff = $signed({1'b0, peak}) - $signed({1'b0, rms_reg});
    wire attack = level_db(peak) > att_db;
    wire release_ok = !rel_inf && level_db(rms_reg) < rel_db && gain_reg < audio_core_pkg::UNITY;
    wire [23:0] gain_next = attack ? ((gain_reg > GAIN_STEP) ? gain_reg - GAIN_STEP : 24'h000000) :
        release_ok ? ((audio_core_pkg::UNITY - gain_reg > GAIN_STEP) ? gain_reg + GAIN_STEP :
        audio_core_pkg::UNITY) : gain_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            gain_reg <= audio_core_pkg::UNITY;
            rms_reg <= 24'h000000;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end else begin
            gain_reg <= pop ? gain_next : gain_reg;
            rms_reg <= pop ? 24'(rms_reg + 24'(rms_diff >>> 4)) : rms_reg;
            out_valid_o <= pop || (out_valid_o && !out_ready_i);
            out_data_o <= pop ? out_next : out_data_o;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_ac_release_code: assert property (!compression_mode_i && limiter_release_threshold_i == 4'h1 |->
        rel_db == -9'sd29) else $error("ac release decode");
    a_drc_attack_code: assert property (compression_mode_i && limiter_attack_threshold_i == 4'hF |->
        att_db == -9'sd4) else $error("drc attack decode");
    a_drc_release_code: assert property (compression_mode_i && limiter_release_threshold_i == 4'h1 |->
        rel_db == att_db - 9'sd38) else $error("drc release decode");
    a_addr_reg_write: assert property (wr_addr |=> coef_addr_reg == $past(reg_wdata_i)) else $error("address write");
    a_addr_reg_read: assert property (reg_addr_i == audio_core_pkg::ADDR_COEF_ADDR |=>
        reg_rdata_o == $past(coef_addr_reg)) else $error("address read");
    a_first_hi_write: assert property (reg_wr_i && reg_addr_i == audio_core_pkg::ADDR_FIRST_HI |=>
        first_coef_data_bits_reg[23:16] == $past(reg_wdata_i)) else $error("first byte");
    a_second_lo_write: assert property (reg_wr_i && reg_addr_i == audio_core_pkg::ADDR_SECOND_LO |=>
        second_coef_data_bits_reg[7:0] == $past(reg_wdata_i)) else $error("second byte");
    a_ram_held_idle: assert property (!coef_xfer_i |=> $stable(coef_mem_reg[0]) &&
        $stable(coef_mem_reg[audio_core_pkg::POST_BASE])) else $error("ram changed");
    a_gain_attack_step: assert property (pop && attack && gain_reg > GAIN_STEP |=>
        gain_reg == $past(gain_reg) - GAIN_STEP) else $error("attack step");
    a_gain_never_above: assert property (gain_reg <= audio_core_pkg::UNITY) else $error("gain cap");
    a_xfer_loads_ram: assert property (coef_xfer_i && coef_addr_reg == 8'h00 |=>
        coef_mem_reg[0] == $past(first_coef_data_bits_reg)) else $error("transfer");

    c_attack: cover property (pop && attack);
    c_release: cover property (pop && release_ok);
    c_out_stall: cover property (out_valid_o && !out_ready_i ##1 out_valid_o && out_ready_i);
endmodule

// ==== core/audio_core_pkg.sv ====
/*
 * constants and carriers for the per-channel audio processing core.
 * assumes one system clock and a byte register port on that clock.
 */
package audio_core_pkg;
    localparam int DW = 24;
    localparam int PW = 28;
    // register offsets
    localparam logic [7:0] ADDR_COEF_ADDR = 8'h16;
    localparam logic [7:0] ADDR_FIRST_HI = 8'h17;
    localparam logic [7:0] ADDR_FIRST_MID = 8'h18;
    localparam logic [7:0] ADDR_FIRST_LO = 8'h19;
    localparam logic [7:0] ADDR_SECOND_HI = 8'h1A;
    localparam logic [7:0] ADDR_SECOND_MID = 8'h1B;
    localparam logic [7:0] ADDR_SECOND_LO = 8'h1C;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // coefficient ram map
    localparam int SLOTS = 5;
    localparam int SLOT_HALF_B0 = 4;
    localparam int MIX_BASE = 10;
    localparam int POST_BASE = 16;
    localparam int XO_BASE = 19;
    localparam int PRE_BASE = 34;
    localparam int COEF_WORDS = 34;
    localparam logic [23:0] HALF_ONE = 24'h400000;
    localparam logic [23:0] UNITY = 24'h7FFFFF;
    localparam logic [23:0] NEG_UNITY = 24'h800000;
    localparam logic [27:0] PRESCALE_RESET = 28'h7FFFFFF;
    localparam logic [23:0] GAIN_STEP_DEF = 24'h000100;
    // limiter thresholds in dB, index is the 4-bit code
    localparam logic signed [7:0] NEG_INF_DB = 8'sh80;
    localparam int DB_PER_BIT = 6;
    localparam logic [0:15][7:0] AC_ATT_DB = '{8'hF4, 8'hF6, 8'hF8, 8'hFA, 8'hFC, 8'hFE, 8'h00, 8'h02,
        8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
    localparam logic [0:15][7:0] AC_REL_DB = '{8'h80, 8'hE3, 8'hEC, 8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF8,
        8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h00};
    localparam logic [0:15][7:0] DRC_ATT_DB = '{8'hE1, 8'hE3, 8'hE5, 8'hE7, 8'hE9, 8'hEB, 8'hED, 8'hEF,
        8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6, 8'hF9, 8'hFC};
    localparam logic [0:15][7:0] DRC_REL_DB = '{8'h80, 8'hDA, 8'hDC, 8'hDF, 8'hE1, 8'hE2, 8'hE4, 8'hE6,
        8'hE8, 8'hEA, 8'hEC, 8'hEE, 8'hF1, 8'hF4, 8'hF7, 8'hFA};
    // stream carriers
    typedef struct packed {
        logic [1:0][23:0] ch;
    } stereo_t;
    typedef struct packed {
        logic [2:0][23:0] ch;
    } trio_t;
endpackage
